// ---- rtl/ass_consts.vh ----
// Purpose: constants for the animated sign sequencer
// Assumes: included by rtl/ass_sequencer.v and by the bench checker and test
// Notes: byte offsets on the apb bus, field positions, reset values
`ifndef ASS_CONSTS_VH
`define ASS_CONSTS_VH

// register byte offsets
`define ASS_CTRL 8'h00
`define ASS_STATUS 8'h04
`define ASS_LAMPS 8'h08
`define ASS_DONE 8'h0C
`define ASS_ENABLE 8'h10
`define ASS_PRESET_BASE 8'h40
`define ASS_PERIOD_BASE 8'h80
`define ASS_WIN_MASK 8'hC0

// control fields
`define ASS_CTRL_RUN 0
`define ASS_CTRL_MODE 1
`define ASS_MODE_COUNTER 1'b0
`define ASS_MODE_TIMER 1'b1

// preset fields: switch-on tenths/seconds, switch-off tenths/seconds
`define ASS_ON_TENTH_LSB 0
`define ASS_ON_SEC_LSB 4
`define ASS_OFF_TENTH_LSB 8
`define ASS_OFF_SEC_LSB 12

// period fields, in mains ticks
`define ASS_DARK_LSB 0
`define ASS_LIT_LSB 16
`define ASS_PERIOD_W 11

// decimal digit limit and timing
`define ASS_DIGIT_MAX 4'h9
`define ASS_MAINS_HZ 50
`define ASS_TICKS_PER_HALF 1
`define ASS_TIMER_MAX_S 20
`define ASS_TIMER_MAX_TICKS (`ASS_TIMER_MAX_S * 2 * `ASS_MAINS_HZ)

// reset values
`define ASS_CTRL_RST 2'h0
`define ASS_PRESET_RST 16'h0000
`define ASS_PERIOD_RST 11'h000

`endif

// ---- rtl/ass_sequencer.v ----
// Purpose: master and slave logic of an animated sign lamp sequencer
// Assumes: mains_phase is a clean square wave synchronous to clk
// Notes: counter mode uses a 10 s decimal cycle, timer mode chains
//   a dark timer and a lit timer in each slave
//
// register map, one aligned 32-bit word each, no byte enables
//   0x00 control: bit 0 run, bit 1 mode (0 counter, 1 timer)
//   0x04 status, read only: [3:0] hundredths digit, [7:4] tenths,
//        [11:8] seconds, bit 12 armed (first start pulse issued)
//   0x08 lamps, read only: one bit per slave output
//   0x0C done, read only: [9:0] dark done, [25:16] lit done
//   0x10 enable: one bit per slave; a disabled slave stays dark
//        and counts as finished for the timer cycle
//   0x40 + 4*i preset of slave i, decimal digits:
//        [3:0] on tenths, [7:4] on seconds,
//        [11:8] off tenths, [15:12] off seconds
//   0x80 + 4*i periods of slave i, in mains ticks of 10 ms:
//        [10:0] dark period, [26:16] lit period
//   any other address answers with pslverr and reads zero
//
// timing
//   pready is always high, so every transfer ends in its first
//   access cycle; read data and error are taken at the setup edge
//   a mains edge gives a tick one cycle later, the digits move on
//   that tick and the lamp follows about three cycles after the edge
//   clearing run acts as a soft reset of counters, timers, outputs
//
// limits a user must know
//   equal on and off presets keep the group dark: off wins
//   each period holds 11 bits of ticks, a little over 20 s; keeping
//   the whole timer cycle within 20 s is left to the user
//   changing mode while running is not guarded: clear run first
//   with no slave enabled in timer mode the start pulse repeats
//   every other cycle, which is harmless but noisy
//
// Overview of operation
// - counter mode derives one tick per mains half-cycle, twice mains rate
// - ticks counted in three cascaded decimal stages, shown to every slave
// - counter cycle is fixed at ten seconds, counters wrap and repeat
// - count reaching a slave's switch-on preset sets its output
// - count reaching a slave's switch-off preset clears its output
// - switch-on preset is a tenths digit and a seconds digit
// - switch-off preset is a tenths digit and a seconds digit
// - timer cycle completes only when all enabled slaves have both done flags
// - start pulse after completion resets all timers and done flags
// - start pulse release starts each slave's dark timer
// - dark timer expiry sets its done flag and starts the lit timer
// - timer mode output is high only while the lit timer runs
// - timer cycle equals the longest dark plus lit sum, up to 20 s
// - a timer master serves up to ten slaves on one start pulse
// - counter master serves up to ten slaves sharing the count
`timescale 1ns/1ps
`include "ass_consts.vh"

module ass_sequencer #(
  parameter NUM_SLAVES = 10
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire mains_phase,
  output reg cycle_start,
  output reg [NUM_SLAVES-1:0] lamp_group_output
);

  // control and configuration state
  reg run;
  reg mode;
  reg [NUM_SLAVES-1:0] slave_enable;
  reg [15:0] preset [0:NUM_SLAVES-1];
  reg [`ASS_PERIOD_W-1:0] dark_period [0:NUM_SLAVES-1];
  reg [`ASS_PERIOD_W-1:0] lit_period [0:NUM_SLAVES-1];

  // master timing state
  reg phase_q;
  reg run_q;
  reg tick;
  reg pos_evt;
  reg armed;
  reg [3:0] digit_hund;
  reg [3:0] digit_tenth;
  reg [3:0] digit_sec;

  // slave timer state
  reg [`ASS_PERIOD_W-1:0] dark_cnt [0:NUM_SLAVES-1];
  reg [`ASS_PERIOD_W-1:0] lit_cnt [0:NUM_SLAVES-1];
  reg [NUM_SLAVES-1:0] dark_timer_done;
  reg [NUM_SLAVES-1:0] lit_timer_done;
  reg [NUM_SLAVES-1:0] dark_running;

  // bus decode
  wire wr_en;
  wire rd_setup;
  wire [3:0] slot;
  wire slot_ok;
  wire in_preset;
  wire in_period;
  wire all_done;
  wire [NUM_SLAVES-1:0] done_pair;
  reg [31:0] next_prdata;
  reg next_pslverr;

  assign pready = 1'b1; // zero-wait slave
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign slot = paddr[5:2];
  assign slot_ok = (slot < NUM_SLAVES);
  assign in_preset = ((paddr & `ASS_WIN_MASK) == `ASS_PRESET_BASE);
  assign in_period = ((paddr & `ASS_WIN_MASK) == `ASS_PERIOD_BASE);

  // a disabled slave never holds the cycle back
  assign done_pair = (dark_timer_done & lit_timer_done) | ~slave_enable;
  assign all_done = &done_pair;

  // global control registers written at the apb access edge
  always @(posedge clk) begin
    if (sys_rst) begin
      run <= 1'b0;
      mode <= `ASS_MODE_COUNTER;
      slave_enable <= {NUM_SLAVES{1'b0}};
    end else if (wr_en) begin
      if (paddr == `ASS_CTRL) begin
        run <= pwdata[`ASS_CTRL_RUN];
        mode <= pwdata[`ASS_CTRL_MODE];
      end
      if (paddr == `ASS_ENABLE) begin
        slave_enable <= pwdata[NUM_SLAVES-1:0];
      end
    end
  end

  // read data and error are captured in the setup cycle
  always @* begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (paddr == `ASS_CTRL) begin
      next_prdata = {30'h00000000, mode, run};
    end else if (paddr == `ASS_STATUS) begin
      next_prdata = {19'h00000, armed, digit_sec, digit_tenth,
        digit_hund};
    end else if (paddr == `ASS_LAMPS) begin
      next_prdata[NUM_SLAVES-1:0] = lamp_group_output;
    end else if (paddr == `ASS_DONE) begin
      next_prdata[NUM_SLAVES-1:0] = dark_timer_done;
      next_prdata[NUM_SLAVES+15:16] = lit_timer_done;
    end else if (paddr == `ASS_ENABLE) begin
      next_prdata[NUM_SLAVES-1:0] = slave_enable;
    end else if (in_preset && slot_ok && paddr[1:0] == 2'h0) begin
      next_prdata[15:0] = preset[slot];
    end else if (in_period && slot_ok && paddr[1:0] == 2'h0) begin
      next_prdata[`ASS_DARK_LSB+`ASS_PERIOD_W-1:`ASS_DARK_LSB] =
        dark_period[slot];
      next_prdata[`ASS_LIT_LSB+`ASS_PERIOD_W-1:`ASS_LIT_LSB] =
        lit_period[slot];
    end else begin
      next_pslverr = 1'b1; // unmapped address
    end
  end

  // hold read data stable through the access phase
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // tick on every mains edge, so twice per mains period
  always @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
      run_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      phase_q <= mains_phase;
      run_q <= run;
      tick <= run & (mains_phase ^ phase_q);
    end
  end

  // three cascaded decimal stages, hundredths to seconds
  always @(posedge clk) begin
    if (sys_rst || !run) begin
      digit_hund <= 4'h0;
      digit_tenth <= 4'h0;
      digit_sec <= 4'h0;
      pos_evt <= 1'b0;
    end else begin
      // a fresh run starts at position zero and is compared once
      pos_evt <= tick | (run & ~run_q);
      if (tick) begin
        if (digit_hund == `ASS_DIGIT_MAX) begin
          digit_hund <= 4'h0;
          if (digit_tenth == `ASS_DIGIT_MAX) begin
            digit_tenth <= 4'h0;
            if (digit_sec == `ASS_DIGIT_MAX) begin
              digit_sec <= 4'h0;
            end else begin
              digit_sec <= digit_sec + 4'h1;
            end
          end else begin
            digit_tenth <= digit_tenth + 4'h1;
          end
        end else begin
          digit_hund <= digit_hund + 4'h1;
        end
      end
    end
  end

  // start pulse: first one on arming, later ones when all slaves finish
  always @(posedge clk) begin
    if (sys_rst || !run || mode != `ASS_MODE_TIMER) begin
      cycle_start <= 1'b0;
      armed <= 1'b0;
    end else begin
      cycle_start <= ~cycle_start & (all_done | ~armed);
      if (cycle_start) begin
        armed <= 1'b1;
      end
    end
  end

  // per-slave configuration, presets and timers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLAVES; gi = gi + 1) begin : g_slave
      wire hit_on;
      wire hit_off;
      wire dark_exp;
      wire lit_exp;
      wire slot_wr;
      // slot number of this slave at the decode width
      localparam [3:0] SLOT_ID = gi;

      assign slot_wr = wr_en && slot == SLOT_ID && paddr[1:0] == 2'h0;

      // tenths and seconds digits picked from the shared count
      assign hit_on = pos_evt && digit_hund == 4'h0 &&
        digit_tenth == preset[gi][`ASS_ON_TENTH_LSB+3:`ASS_ON_TENTH_LSB] &&
        digit_sec == preset[gi][`ASS_ON_SEC_LSB+3:`ASS_ON_SEC_LSB];
      assign hit_off = pos_evt && digit_hund == 4'h0 &&
        digit_tenth == preset[gi][`ASS_OFF_TENTH_LSB+3:`ASS_OFF_TENTH_LSB] &&
        digit_sec == preset[gi][`ASS_OFF_SEC_LSB+3:`ASS_OFF_SEC_LSB];

      assign dark_exp = dark_cnt[gi] >= dark_period[gi];
      assign lit_exp = lit_cnt[gi] >= lit_period[gi];

      // preset and period registers of this slave
      always @(posedge clk) begin
        if (sys_rst) begin
          preset[gi] <= `ASS_PRESET_RST;
          dark_period[gi] <= `ASS_PERIOD_RST;
          lit_period[gi] <= `ASS_PERIOD_RST;
        end else if (slot_wr && in_preset) begin
          preset[gi] <= pwdata[15:0];
        end else if (slot_wr && in_period) begin
          dark_period[gi] <=
            pwdata[`ASS_DARK_LSB+`ASS_PERIOD_W-1:`ASS_DARK_LSB];
          lit_period[gi] <=
            pwdata[`ASS_LIT_LSB+`ASS_PERIOD_W-1:`ASS_LIT_LSB];
        end
      end

      // dark timer then lit timer, both counting mains ticks
      always @(posedge clk) begin
        if (sys_rst || !run || mode != `ASS_MODE_TIMER ||
            !slave_enable[gi] || cycle_start) begin
          dark_cnt[gi] <= `ASS_PERIOD_RST;
          lit_cnt[gi] <= `ASS_PERIOD_RST;
          dark_timer_done[gi] <= 1'b0;
          lit_timer_done[gi] <= 1'b0;
          dark_running[gi] <= 1'b0;
        end else if (!armed) begin
          dark_running[gi] <= 1'b0;
        end else if (!dark_timer_done[gi]) begin
          dark_running[gi] <= 1'b1;
          if (dark_exp) begin
            dark_timer_done[gi] <= 1'b1;
          end else if (tick) begin
            dark_cnt[gi] <= dark_cnt[gi] + 1'b1;
          end
        end else if (!lit_timer_done[gi]) begin
          if (lit_exp) begin
            lit_timer_done[gi] <= 1'b1;
          end else if (tick) begin
            lit_cnt[gi] <= lit_cnt[gi] + 1'b1;
          end
        end
      end

      // lamp output per mode
      always @(posedge clk) begin
        if (sys_rst || !run || !slave_enable[gi]) begin
          lamp_group_output[gi] <= 1'b0;
        end else if (mode == `ASS_MODE_TIMER) begin
          // lit only between the two expiries
          lamp_group_output[gi] <= dark_timer_done[gi] &
            ~lit_timer_done[gi] & ~cycle_start &
            ~(lit_exp & dark_timer_done[gi]);
        end else if (hit_off) begin
          lamp_group_output[gi] <= 1'b0;
        end else if (hit_on) begin
          lamp_group_output[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // one parameter sizes both masters; ten is the documented ceiling

endmodule // ass_sequencer

// ---- bench/ass_mains_model.sv ----
// Purpose: mains source feeding the sequencer's polarity input
// Assumes: half period given in clk cycles, kept short for run time
// Notes: counts every polarity change so the bench can time ticks
`timescale 1ns/1ps
module ass_mains_model #(
  parameter HALF = 16
) (
  input wire logic clk,
  output logic mains_phase,
  output int edges
);
  int cnt;
  initial begin
    mains_phase = 1'b0;
    edges = 0;
    cnt = 0;
  end
  // two polarity changes per mains period
  always @(posedge clk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      mains_phase <= ~mains_phase;
      edges <= edges + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ass_mains_model

// ---- bench/ass_sequencer_properties.sv ----
// Purpose: port checks for the sign sequencer
// Assumes: zero-wait apb slave with registered read data
// Notes: bound to the sequencer after the module
`timescale 1ns/1ps
`include "ass_consts.vh"
module ass_seq_checker #(
  parameter NUM_SLAVES = 10
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire mains_phase,
  input wire cycle_start,
  input wire [NUM_SLAVES-1:0] lamp_group_output
);
  // setup cycle, unmapped gap, and the five base registers
  wire setup = psel && !penable;
  wire hole = paddr > `ASS_ENABLE && paddr < `ASS_PRESET_BASE;
  wire base = paddr <= `ASS_ENABLE && paddr[1:0] == 2'h0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_reset_clears: assert property (disable iff (1'b0)
    sys_rst |=> lamp_group_output == '0 && !cycle_start)
    else $error("outputs not cleared by reset");
  a_start_single: assert property (
    cycle_start |=> !cycle_start)
    else $error("start pulse longer than one cycle");
  a_start_dark: assert property (
    cycle_start |=> lamp_group_output == '0)
    else $error("lamp lit across start pulse");
  a_hole_err: assert property (setup && hole |=> pslverr)
    else $error("no error on unmapped address");
  a_base_ok: assert property (setup && base |=> !pslverr)
    else $error("error on mapped address");
  a_hole_zero: assert property (setup && hole && !pwrite |=> prdata == 0)
    else $error("unmapped read not zero");
  a_lamp_read: assert property (setup && !pwrite && paddr == `ASS_LAMPS
    |=> prdata[NUM_SLAVES-1:0] == $past(lamp_group_output))
    else $error("lamp readback differs from outputs");
  c_start: cover property (cycle_start);
  c_lamp: cover property ($rose(lamp_group_output[0]));
  c_err: cover property (setup ##1 pslverr);
endmodule // ass_seq_checker
bind ass_sequencer ass_seq_checker #(.NUM_SLAVES(NUM_SLAVES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mains_phase(mains_phase),
  .cycle_start(cycle_start), .lamp_group_output(lamp_group_output));

// ---- bench/test_animated_sign_sequencer.sv ----
// Purpose: self-checking bench for the sign sequencer
// Assumes: fast mains model, 16 clk cycles per half period
// Notes: register rows first, then counter, timer and reset cases
`timescale 1ns/1ps
`include "ass_consts.vh"
module test_animated_sign_sequencer;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mains_phase, cycle_start, er;
  logic [9:0] lamp_group_output;
  logic seen2 = 1'b0;
  int edges, mark, n_errors = 0, checked = 0;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic e;} ass_row_t;
  ass_row_t rows[9] = '{'{8'h20, 32'hFFFFFFFF, 0, 1},
    '{8'h42, 32'hFFFF, 0, 1}, '{8'h70, 32'h1234, 0, 1},
    '{`ASS_ENABLE, 32'h3FF, 32'h3FF, 0},
    '{8'h40, 32'h0502, 32'h0502, 0}, '{8'h44, 32'h0300, 32'h0300, 0},
    '{8'h48, 32'h0101, 32'h0101, 0}, '{8'h80, 32'h50003, 32'h50003, 0},
    '{8'h84, 32'h2000A, 32'h2000A, 0}};
  wire [10:0] obs = {cycle_start, lamp_group_output};
  always #2.5 clk = ~clk;
  ass_sequencer uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mains_phase(mains_phase), .cycle_start(cycle_start),
    .lamp_group_output(lamp_group_output));
  ass_mains_model mains (.clk(clk), .mains_phase(mains_phase),
    .edges(edges));
  // slave 2 has equal presets, so it must never light
  always @(posedge clk) if (lamp_group_output[2] === 1'b1) seen2 <= 1'b1;
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bail;
    n_errors++;
    end_sim();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 100);
    if (i == 100) bail();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_bit(input int s, input logic v);
    int i;
    for (i = 0; i < 40000 && obs[s] !== v; i++) @(negedge clk);
    if (i == 40000) bail();
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, `ASS_CTRL, 0);
    chk(rd, 0);
    apb(0, `ASS_LAMPS, 0);
    chk(rd, 0);
    foreach (rows[k]) begin
      apb(1, rows[k].a, rows[k].w);
      chk({31'h0, er}, {31'h0, rows[k].e});
      apb(0, rows[k].a, 0);
      chk(rd, rows[k].r);
      chk({31'h0, er}, {31'h0, rows[k].e});
    end
    // counter mode: slave 0 on 0.2 s off 0.5 s, slave 1 on 0.0 off 0.3
    apb(1, `ASS_CTRL, 32'h1);
    wait_bit(0, 1'b1);
    mark = edges;
    apb(0, `ASS_STATUS, 0);
    chk({20'h0, rd[11:0]}, 32'h020);
    chk({31'h0, lamp_group_output[1]}, 32'h1);
    wait_bit(0, 1'b0);
    apb(0, `ASS_STATUS, 0);
    chk({20'h0, rd[11:0]}, 32'h050);
    chk({31'h0, lamp_group_output[1]}, 32'h0);
    wait_bit(0, 1'b1);
    chk(32'(edges - mark), 32'd1000);
    chk({31'h0, seen2}, 32'h0);
    // timer mode: slave 0 dark 3 lit 5, slave 1 dark 10 lit 2
    apb(1, `ASS_CTRL, 0);
    apb(1, `ASS_ENABLE, 32'h3);
    apb(1, `ASS_CTRL, 32'h3);
    wait_bit(10, 1'b1);
    mark = edges;
    wait_bit(0, 1'b1);
    chk(32'(edges - mark), 32'd3);
    wait_bit(0, 1'b0);
    chk(32'(edges - mark), 32'd8);
    wait_bit(1, 1'b1);
    chk(32'(edges - mark), 32'd10);
    wait_bit(10, 1'b1);
    chk(32'(edges - mark), 32'd12);
    chk({31'h0, seen2}, 32'h0);
    // reset in mid-run, driven just after a rising edge
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, `ASS_CTRL, 0);
    chk(rd, 0);
    chk({22'h0, lamp_group_output}, 0);
    end_sim();
  end
endmodule // test_animated_sign_sequencer
